// ===== inc/can_test_pkg.sv
// shared constants and types for the can test-mode control block
package can_test_pkg;
  // register byte offsets on the wishbone port
  localparam logic [7:0] MASTER_CONTROL_OFS = 8'h00;
  localparam logic [7:0] ERROR_COUNTER_OFS = 8'h04;
  localparam logic [7:0] ERROR_STATUS_OFS = 8'h08;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  // master_control fields
  localparam int MC_W = 16;
  localparam logic [MC_W-1:0] MASTER_CONTROL_RESET = 16'h0000;
  localparam int TEST_MODE_ENABLE_POS = 15;
  localparam int ERROR_COUNTER_WRITE_ENABLE_POS = 14;
  localparam int FORCE_ERROR_PASSIVE_POS = 13;
  localparam int TEST_OPT_LSB = 8;
  localparam int TEST_OPT_W = 7;
  // option index inside test_option_bits
  localparam int OPT_CNT_WE = ERROR_COUNTER_WRITE_ENABLE_POS - TEST_OPT_LSB;
  localparam int OPT_FORCE_PASSIVE = FORCE_ERROR_PASSIVE_POS - TEST_OPT_LSB;
  // error counter word: transmit count in the upper byte, receive in the lower
  localparam int TEC_LSB = 8;
  localparam int REC_LSB = 0;
  localparam int LOAD_W = 8;
  localparam int ERR_CNT_W = 9;
  localparam int PASSIVE_LIMIT = 128;
  localparam int BUS_OFF_LIMIT = 256;
  localparam int TEC_ERR_STEP = 8;
  localparam int CNT_STEP = 1;
  // error status word
  localparam int STATE_LSB = 0;
  localparam int HALTED_POS = 8;
  localparam int STATE_W = 3;
  typedef enum logic [STATE_W-1:0] {
    ERR_ACTIVE = 3'h1,
    ERR_PASSIVE = 3'h2,
    ERR_BUS_OFF = 3'h4
  } err_state_t;
endpackage : can_test_pkg

// ===== inc/err_cnt_if.sv
// carrier between register logic, error counters and error state generator
`timescale 1ns/1ps
interface err_cnt_if #(parameter int CNT_W = 9);
  logic load;
  logic [7:0] load_val;
  logic [CNT_W-1:0] transmit_error_counter;
  logic [CNT_W-1:0] receive_error_counter;
  logic force_passive;
  can_test_pkg::err_state_t err_state;
  modport ctl(output load, load_val, force_passive, input transmit_error_counter, receive_error_counter, err_state);
  modport cnt(input load, load_val, output transmit_error_counter, receive_error_counter);
  modport st(input transmit_error_counter, receive_error_counter, force_passive, output err_state);
endinterface : err_cnt_if

// ===== hw/err_counters.sv
// transmit and receive error counters with host load path
`timescale 1ns/1ps
module err_counters import can_test_pkg::*; #(
  parameter int CNT_W = ERR_CNT_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register side
  err_cnt_if.cnt ec,
  // protocol engine events, one-cycle pulses
  input wire logic tx_err_i,
  input wire logic tx_ok_i,
  input wire logic rx_err_i,
  input wire logic rx_ok_i
);
  logic [CNT_W-1:0] tec_r, tec_nxt, rec_r, rec_nxt;

  // saturating step so a burst of errors cannot wrap the count back to zero
  function automatic logic [CNT_W-1:0] sat_step(input logic [CNT_W-1:0] v,
      input logic [CNT_W-1:0] up, input logic [CNT_W-1:0] dn);
    logic [CNT_W:0] s;
    s = {1'b0, v} + {1'b0, up};
    if (s[CNT_W]) s = {1'b0, {CNT_W{1'b1}}};
    if (s[CNT_W-1:0] < dn) return '0;
    return s[CNT_W-1:0] - dn;
  endfunction : sat_step

  always_comb begin
    if (ec.load) begin
      tec_nxt = CNT_W'(ec.load_val);
      rec_nxt = CNT_W'(ec.load_val);
    end else begin
      tec_nxt = sat_step(tec_r, tx_err_i ? CNT_W'(TEC_ERR_STEP) : '0,
                         tx_ok_i ? CNT_W'(CNT_STEP) : '0);
      rec_nxt = sat_step(rec_r, rx_err_i ? CNT_W'(CNT_STEP) : '0,
                         rx_ok_i ? CNT_W'(CNT_STEP) : '0);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tec_r <= '0;
      rec_r <= '0;
    end else begin
      tec_r <= tec_nxt;
      rec_r <= rec_nxt;
    end
  end

  assign ec.transmit_error_counter = tec_r;
  assign ec.receive_error_counter = rec_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  load_both_equal_a: assert property (ec.load |=> (tec_r == CNT_W'($past(ec.load_val)))
      && (rec_r == tec_r)) else $error("counter load did not copy value");
  load_no_busoff_a: assert property (ec.load |=> tec_r < CNT_W'(BUS_OFF_LIMIT))
      else $error("counter load reached bus-off");
endmodule : err_counters

// ===== hw/err_state_gen.sv
// error state derived from counters, with forced passive override
`timescale 1ns/1ps
module err_state_gen import can_test_pkg::*; #(
  parameter int CNT_W = ERR_CNT_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // counters in, state out
  err_cnt_if.st ec
);
  err_state_t st_r, st_nxt;

  always_comb begin
    if (ec.force_passive) begin
      st_nxt = ERR_PASSIVE;
    end else if (ec.transmit_error_counter >= CNT_W'(BUS_OFF_LIMIT)) begin
      st_nxt = ERR_BUS_OFF;
    end else if (ec.transmit_error_counter >= CNT_W'(PASSIVE_LIMIT) || ec.receive_error_counter >= CNT_W'(PASSIVE_LIMIT)) begin
      st_nxt = ERR_PASSIVE;
    end else begin
      st_nxt = ERR_ACTIVE;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) st_r <= ERR_ACTIVE;
    else st_r <= st_nxt;
  end

  assign ec.err_state = st_r;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  forced_passive_a: assert property (ec.force_passive |=> st_r == ERR_PASSIVE)
      else $error("forced passive not honoured");
  counter_active_a: assert property (!ec.force_passive && ec.transmit_error_counter < CNT_W'(PASSIVE_LIMIT)
      && ec.receive_error_counter < CNT_W'(PASSIVE_LIMIT) |=> st_r == ERR_ACTIVE)
      else $error("low counters did not give active");
  counter_busoff_a: assert property (!ec.force_passive && ec.transmit_error_counter >= CNT_W'(BUS_OFF_LIMIT)
      |=> st_r == ERR_BUS_OFF) else $error("high count did not give bus-off");
endmodule : err_state_gen

// ===== hw/can_test_mode_control.sv
// test-mode control bits of the can master control register, wishbone slave
//
// Notes on behaviour
// - bit 15 selects test (1) or normal (0) operation; read/write, resets 0.
// - option bits take effect only while test mode enable is 1.
// - bit 14 makes both error counters writable by host while halted_i is 1; read/write, resets 0.
// - one host write loads both counters with the transmit counter value.
// - loaded value is at most 255, so a load never reaches bus-off.
// - with bit 14 clear, host writes leave both counters unchanged.
// - bit 13 forces error-passive behaviour whatever the counters; resets 0.
// - with bit 13 clear, error state follows the counters only.
`timescale 1ns/1ps
module can_test_mode_control import can_test_pkg::*; #(
  parameter int CNT_W = ERR_CNT_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // protocol engine status and events
  input wire logic halted_i,
  input wire logic tx_err_i,
  input wire logic tx_ok_i,
  input wire logic rx_err_i,
  input wire logic rx_ok_i,
  // control towards the protocol engine
  output logic test_mode_o,
  output logic [TEST_OPT_W-1:0] test_option_o,
  output logic [STATE_W-1:0] err_state_o
);
  err_cnt_if #(.CNT_W(CNT_W)) ec();

  logic [MC_W-1:0] mc_r, mc_nxt;
  logic [TEST_OPT_W-1:0] opt_r, opt_nxt;
  logic ack_r, ack_nxt;
  logic [DATA_W-1:0] dat_r, dat_nxt;
  logic req;
  logic wr_mc;
  logic wr_cnt;
  logic cnt_load;

  // effective options: zero while test mode is off
  function automatic logic [TEST_OPT_W-1:0] gate_opts(input logic [MC_W-1:0] mc);
    if (mc[TEST_MODE_ENABLE_POS]) return mc[TEST_OPT_LSB +: TEST_OPT_W];
    return '0;
  endfunction : gate_opts

  // bus decode; a request is taken once, in the cycle before ack
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_mc = req && wb_we_i && wb_adr_i == MASTER_CONTROL_OFS && wb_sel_i[1];
  assign wr_cnt = req && wb_we_i && wb_adr_i == ERROR_COUNTER_OFS && wb_sel_i[1];
  // halted state is sampled by the block itself, software ordering is not trusted
  assign cnt_load = wr_cnt && halted_i && opt_r[OPT_CNT_WE];

  // master control register
  always_comb begin
    mc_nxt = mc_r;
    if (wr_mc) begin
      // only the test byte is implemented, the low byte reads zero
      mc_nxt[TEST_OPT_LSB +: 8] = wb_dat_i[TEST_OPT_LSB +: 8];
    end
    opt_nxt = gate_opts(mc_nxt);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mc_r <= MASTER_CONTROL_RESET;
      opt_r <= '0;
    end else begin
      mc_r <= mc_nxt;
      opt_r <= opt_nxt;
    end
  end

  // bus answer: one cycle after the request, read data registered with it
  always_comb begin
    ack_nxt = req;
    dat_nxt = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        MASTER_CONTROL_OFS: dat_nxt[MC_W-1:0] = mc_r;
        ERROR_COUNTER_OFS: begin
          dat_nxt[TEC_LSB +: LOAD_W] = ec.transmit_error_counter[LOAD_W-1:0];
          dat_nxt[REC_LSB +: LOAD_W] = ec.receive_error_counter[LOAD_W-1:0];
        end
        ERROR_STATUS_OFS: begin
          dat_nxt[STATE_LSB +: STATE_W] = ec.err_state;
          dat_nxt[HALTED_POS] = halted_i;
        end
        default: dat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // counter load always takes the transmit byte, its limit is the byte width
  assign ec.load = cnt_load;
  assign ec.load_val = wb_dat_i[TEC_LSB +: LOAD_W];
  assign ec.force_passive = opt_r[OPT_FORCE_PASSIVE];

  err_counters #(.CNT_W(CNT_W)) u_counters (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ec(ec.cnt),
    .tx_err_i(tx_err_i),
    .tx_ok_i(tx_ok_i),
    .rx_err_i(rx_err_i),
    .rx_ok_i(rx_ok_i)
  );

  err_state_gen #(.CNT_W(CNT_W)) u_state (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ec(ec.st)
  );

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign test_mode_o = mc_r[TEST_MODE_ENABLE_POS];
  assign test_option_o = opt_r;
  assign err_state_o = ec.err_state;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  test_mode_write_a: assert property (wr_mc |=> test_mode_o == $past(wb_dat_i[15]))
      else $error("test mode bit not written");
  options_gated_a: assert property (!test_mode_o |-> test_option_o == '0)
      else $error("options active outside test mode");
  options_follow_a: assert property (test_mode_o |-> test_option_o == mc_r[14:8])
      else $error("options not passed in test mode");
  counter_we_load_a: assert property (wr_cnt && halted_i && test_mode_o && mc_r[14]
      |=> ec.transmit_error_counter[7:0] == $past(wb_dat_i[15:8]) && ec.receive_error_counter[7:0] == $past(wb_dat_i[15:8]))
      else $error("enabled counter write lost");
  counter_readonly_a: assert property (wr_cnt && !mc_r[14] && !tx_err_i && !tx_ok_i
      && !rx_err_i && !rx_ok_i |=> $stable(ec.transmit_error_counter) && $stable(ec.receive_error_counter))
      else $error("read-only counters changed");
  load_guard_a: assert property (ec.load |-> halted_i && test_mode_o && mc_r[14])
      else $error("counter load without its conditions");
  force_passive_out_a: assert property (test_mode_o && mc_r[13] |=> err_state_o == 3'h2)
      else $error("forced passive missing at output");
  ack_single_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle");
endmodule : can_test_mode_control

// ===== testbench/wb_host.sv
// wishbone classic master standing in for the host cpu
`timescale 1ns/1ps
module wb_host import can_test_pkg::*; (
  // clock
  input wire logic core_clk_i,
  // bus towards the slave
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [ADDR_W-1:0] wb_adr_o,
  output logic [SEL_W-1:0] wb_sel_o,
  output logic [DATA_W-1:0] wb_dat_o,
  // answer
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  task automatic xfer(input logic we, input logic [ADDR_W-1:0] adr,
      input logic [DATA_W-1:0] dat, output logic [DATA_W-1:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'hF;
    wb_dat_o <= dat;
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 64);
    rd = wb_dat_i;
    ok = (wb_ack_i === 1'b1);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    // released lines must not keep looking valid
    wb_adr_o <= ~adr;
    wb_dat_o <= ~dat;
  endtask : xfer
endmodule : wb_host

// ===== testbench/can_test_mode_control_test.sv
// self-checking bench for the can test-mode control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module can_test_mode_control_test import can_test_pkg::*; ();
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic halted_i = 1'b0;
  logic [3:0] ev_r = 4'h0;
  logic cyc, stb, we, ack, ok, mode;
  logic [ADDR_W-1:0] adr;
  logic [SEL_W-1:0] sel;
  logic [DATA_W-1:0] wdat, rdat, rd;
  logic [TEST_OPT_W-1:0] opt;
  logic [STATE_W-1:0] st;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [1:0][15:0] mc_tab;

  always #20 core_clk_i = ~core_clk_i;

  wb_host i_host (.core_clk_i(core_clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));

  can_test_mode_control i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .halted_i(halted_i), .tx_err_i(ev_r[0]),
    .tx_ok_i(ev_r[1]), .rx_err_i(ev_r[2]), .rx_ok_i(ev_r[3]), .test_mode_o(mode),
    .test_option_o(opt), .err_state_o(st));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : wt

  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_host.xfer(w, a, d, rd, ok);
    if (!ok) begin
      n_mismatch++;
      complete_run();
    end
  endtask : acc

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, string nm);
    acc(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rd_chk

  // each engine event is a one-cycle pulse
  task automatic ev(input int k, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      ev_r[k] <= 1'b1;
      @(posedge core_clk_i);
      ev_r[k] <= 1'b0;
    end
    wt(3);
  endtask : ev

  task automatic t_reset();
    rd_chk(MASTER_CONTROL_OFS, 32'h0, "mc");
    `CHK("mode", 1'b0, mode)
    `CHK("state", ERR_ACTIVE, st)
    rd_chk(8'h0C, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_options();
    acc(1'b1, MASTER_CONTROL_OFS, 32'h7F00);
    wt(2);
    `CHK("opt", 7'h00, opt)
    rd_chk(MASTER_CONTROL_OFS, 32'h7F00, "mc");
    acc(1'b1, MASTER_CONTROL_OFS, 32'hFF00);
    wt(2);
    `CHK("mode", 1'b1, mode)
    `CHK("opt", 7'h7F, opt)
  endtask : t_options

  task automatic t_load();
    @(posedge core_clk_i);
    halted_i <= 1'b1;
    acc(1'b1, MASTER_CONTROL_OFS, 32'hC000);
    acc(1'b1, ERROR_COUNTER_OFS, 32'hFF12);
    wt(3);
    rd_chk(ERROR_COUNTER_OFS, 32'hFFFF, "cnt");
    `CHK("state", ERR_PASSIVE, st)
    ev(0, 1);
    `CHK("state", ERR_BUS_OFF, st)
    rd_chk(ERROR_STATUS_OFS, 32'h104, "status");
    acc(1'b1, ERROR_COUNTER_OFS, 32'h1000);
    wt(3);
    rd_chk(ERROR_COUNTER_OFS, 32'h1010, "cnt");
    `CHK("state", ERR_ACTIVE, st)
  endtask : t_load

  // halt off, enable gated by normal mode, enable clear
  task automatic t_refuse();
    mc_tab = {16'h8000, 16'h4000};
    for (int i = 0; i < 3; i++) begin
      halted_i <= (i != 0);
      acc(1'b1, MASTER_CONTROL_OFS, (i == 0) ? 32'hC000 : {16'h0, mc_tab[i-1]});
      acc(1'b1, ERROR_COUNTER_OFS, 32'h5A00);
      wt(2);
      rd_chk(ERROR_COUNTER_OFS, 32'h1010, "cnt");
    end
  endtask : t_refuse

  task automatic t_force();
    acc(1'b1, MASTER_CONTROL_OFS, 32'hA000);
    wt(3);
    `CHK("state", ERR_PASSIVE, st)
    acc(1'b1, MASTER_CONTROL_OFS, 32'h2000);
    wt(3);
    `CHK("state", ERR_ACTIVE, st)
    acc(1'b1, MASTER_CONTROL_OFS, 32'h8000);
    ev(2, 130);
    `CHK("state", ERR_PASSIVE, st)
    ev(3, 20);
    ev(1, 1);
    `CHK("state", ERR_ACTIVE, st)
    rd_chk(ERROR_COUNTER_OFS, 32'h0F7E, "cnt");
  endtask : t_force

  // mid-run reset: control bits and both counters must fall back at once
  task automatic t_rerun();
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wt(1);
    `CHK("mode", 1'b0, mode)
    `CHK("opt", 7'h00, opt)
    `CHK("state", ERR_ACTIVE, st)
    rd_chk(MASTER_CONTROL_OFS, 32'h0, "mc");
    rd_chk(ERROR_COUNTER_OFS, 32'h0, "cnt");
  endtask : t_rerun

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wt(1);
    t_reset();
    t_options();
    t_load();
    t_refuse();
    t_force();
    t_rerun();
    complete_run();
  end
endmodule : can_test_mode_control_test
